/* File: logic/ssw_defines.vh */
`ifndef SSW_DEFINES_VH
`define SSW_DEFINES_VH

// clock period in ns (100 MHz)
`define SSW_CLK_PERIOD_NS   10
// kick qualification time in ns
`define SSW_KICK_QUAL_NS    100
// reset countdown in ms
`define SSW_RST_TIME_MS     200
// watchdog timeout in ms (1.6 s)
`define SSW_WD_TIME_MS      1600
`define SSW_CYC_PER_MS      (1000000 / `SSW_CLK_PERIOD_NS)
// least time rounds up
`define SSW_KICK_QUAL_CYC   ((`SSW_KICK_QUAL_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_RST_CYC         (`SSW_RST_TIME_MS * `SSW_CYC_PER_MS)
`define SSW_WD_CYC          (`SSW_WD_TIME_MS * `SSW_CYC_PER_MS)
`define SSW_CNT_W           28
`define SSW_QUAL_W          8
`define SSW_SYNC_RESET_VAL  1'b0
// synchroniser bit positions
`define SSW_SYNC_W          5
`define SSW_SYNC_SUPPLY     4
`define SSW_SYNC_THR        3
`define SSW_SYNC_MR         2
`define SSW_SYNC_KICK       1
`define SSW_SYNC_FLOAT      0

`endif

/* File: logic/ssw_sync.v */
`timescale 1ns/1ps
`include "ssw_defines.vh"

module ssw_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             arst_n_i,
    input  wire [WIDTH-1:0] d_i,
    output reg  [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] meta_q;

    // first stage read only by the second
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= {WIDTH{`SSW_SYNC_RESET_VAL}};
            q_o    <= {WIDTH{`SSW_SYNC_RESET_VAL}};
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

/* File: logic/ssw_supervisor.v */
`timescale 1ns/1ps
`include "ssw_defines.vh"

// What this block does
// - threshold output follows threshold comparator flag
// - floating kick holds watchdog reset, alarm high unless supply low
// - watchdog inactive while system reset low
// - qualified kick change restarts watchdog timer
// - no kick within timeout drives alarm low
// - reset held low while supply low
// - reset released after full countdown
// - supply dip during countdown clears timer
// - supply drop asserts and holds reset
// - manual reset low forces reset, clears timer
// - manual reset release starts full countdown
// - alarm low until supply reaches threshold
// - watchdog enabled only after reset release
// - kick activity raises alarm, rearms timer
// - supply drop forces alarm and reset together
module ssw_supervisor #(
    parameter RST_CYC = `SSW_RST_CYC,
    parameter WD_CYC  = `SSW_WD_CYC
) (
    input  wire clk_i,
    input  wire arst_n_i,
    input  wire supply_low_i,
    input  wire threshold_sense_low_i,
    input  wire manual_reset_n,
    input  wire kick_in,
    input  wire kick_float_i,
    output reg  sys_reset_n_o,
    output reg  watchdog_alarm_n,
    output reg  threshold_low_n
);

    localparam integer RST_LAST_I  = RST_CYC - 1;
    localparam integer WD_LAST_I   = WD_CYC - 1;
    localparam integer QUAL_LAST_I = `SSW_KICK_QUAL_CYC - 1;
    // counts are cut to the counter width on purpose
    localparam [`SSW_CNT_W-1:0]  RST_LAST  = RST_LAST_I[`SSW_CNT_W-1:0];
    localparam [`SSW_CNT_W-1:0]  WD_LAST   = WD_LAST_I[`SSW_CNT_W-1:0];
    localparam [`SSW_QUAL_W-1:0] QUAL_LAST = QUAL_LAST_I[`SSW_QUAL_W-1:0];

    // terminal count decode, shared by both timers
    function at_last;
        input [`SSW_CNT_W-1:0] cnt;
        input [`SSW_CNT_W-1:0] last;
        begin
            at_last = (cnt == last);
        end
    endfunction

    wire [`SSW_SYNC_W-1:0] sync_w;
    wire       supply_low_s;
    wire       thr_low_s;
    wire       mr_n_s;
    wire       kick_s;
    wire       float_s;

    ssw_sync #(
        .WIDTH (`SSW_SYNC_W)
    ) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({supply_low_i, threshold_sense_low_i, ~manual_reset_n,
                    kick_in, kick_float_i}),
        .q_o      (sync_w)
    );

    // synchroniser resets to 0, so manual reset is carried inverted
    assign supply_low_s = sync_w[`SSW_SYNC_SUPPLY];
    assign thr_low_s    = sync_w[`SSW_SYNC_THR];
    assign mr_n_s       = ~sync_w[`SSW_SYNC_MR];
    assign kick_s       = sync_w[`SSW_SYNC_KICK];
    assign float_s      = sync_w[`SSW_SYNC_FLOAT];

    reg [`SSW_CNT_W-1:0]  rst_cnt_q;
    reg                   rst_run_q;
    reg [`SSW_CNT_W-1:0]  wd_cnt_q;
    reg                   wd_run_q;
    reg                   kick_stable_q;
    reg [`SSW_QUAL_W-1:0] qual_cnt_q;
    reg                   kick_evt_q;

    wire reset_hold = supply_low_s | ~mr_n_s;

    reg                   kick_stable_d;
    reg [`SSW_QUAL_W-1:0] qual_cnt_d;
    reg                   kick_evt_d;

    // kick change must persist the qualification time
    always @* begin
        kick_stable_d = kick_stable_q;
        qual_cnt_d    = qual_cnt_q;
        kick_evt_d    = 1'b0;
        if (float_s || kick_s == kick_stable_q) begin
            // a floating pin tracks silently, so release makes no false kick
            qual_cnt_d = {`SSW_QUAL_W{1'b0}};
            if (float_s) begin
                kick_stable_d = kick_s;
            end
        end else if (qual_cnt_q == QUAL_LAST) begin
            qual_cnt_d    = {`SSW_QUAL_W{1'b0}};
            kick_stable_d = kick_s;
            kick_evt_d    = 1'b1;
        end else begin
            qual_cnt_d = qual_cnt_q + 1'b1;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            kick_stable_q <= 1'b0;
            qual_cnt_q    <= {`SSW_QUAL_W{1'b0}};
            kick_evt_q    <= 1'b0;
        end else begin
            kick_stable_q <= kick_stable_d;
            qual_cnt_q    <= qual_cnt_d;
            kick_evt_q    <= kick_evt_d;
        end
    end

    reg [`SSW_CNT_W-1:0] rst_cnt_d;
    reg                  rst_run_d;
    reg                  sys_reset_n_d;

    // reset timer; power-on starts a countdown even with a good supply
    always @* begin
        rst_cnt_d     = rst_cnt_q;
        rst_run_d     = rst_run_q;
        sys_reset_n_d = sys_reset_n_o;
        if (reset_hold) begin
            // supply low holds reset; clear countdown
            // supply drop asserts reset; manual reset
            rst_cnt_d     = {`SSW_CNT_W{1'b0}};
            rst_run_d     = 1'b1;
            sys_reset_n_d = 1'b0;
        end else if (rst_run_q) begin
            // full countdown then release; same after manual
            if (at_last(rst_cnt_q, RST_LAST)) begin
                rst_run_d     = 1'b0;
                sys_reset_n_d = 1'b1;
            end else begin
                rst_cnt_d = rst_cnt_q + 1'b1;
            end
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_cnt_q     <= {`SSW_CNT_W{1'b0}};
            rst_run_q     <= 1'b1;
            sys_reset_n_o <= 1'b0;
        end else begin
            rst_cnt_q     <= rst_cnt_d;
            rst_run_q     <= rst_run_d;
            sys_reset_n_o <= sys_reset_n_d;
        end
    end

    reg [`SSW_CNT_W-1:0] wd_cnt_d;
    reg                  wd_run_d;
    reg                  alarm_n_d;

    // watchdog timer and alarm; supply low outranks a floating kick
    always @* begin
        wd_cnt_d  = wd_cnt_q;
        wd_run_d  = wd_run_q;
        alarm_n_d = watchdog_alarm_n;
        if (supply_low_s) begin
            // supply drop forces alarm low; power-up low
            wd_cnt_d  = {`SSW_CNT_W{1'b0}};
            wd_run_d  = 1'b0;
            alarm_n_d = 1'b0;
        end else if (float_s) begin
            wd_cnt_d  = {`SSW_CNT_W{1'b0}};
            wd_run_d  = 1'b0;
            alarm_n_d = 1'b1;
        end else if (!sys_reset_n_o || reset_hold) begin
            // inactive during reset; armed after release
            wd_cnt_d  = {`SSW_CNT_W{1'b0}};
            wd_run_d  = 1'b1;
            alarm_n_d = 1'b1;
        end else if (kick_evt_q) begin
            wd_cnt_d  = {`SSW_CNT_W{1'b0}};
            wd_run_d  = 1'b1;
            alarm_n_d = 1'b1;
        end else if (wd_run_q) begin
            // timeout stops timer, alarm low; cycle count
            if (at_last(wd_cnt_q, WD_LAST)) begin
                wd_run_d  = 1'b0;
                alarm_n_d = 1'b0;
            end else begin
                wd_cnt_d = wd_cnt_q + 1'b1;
            end
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wd_cnt_q         <= {`SSW_CNT_W{1'b0}};
            wd_run_q         <= 1'b0;
            watchdog_alarm_n <= 1'b0;
        end else begin
            wd_cnt_q         <= wd_cnt_d;
            wd_run_q         <= wd_run_d;
            watchdog_alarm_n <= alarm_n_d;
        end
    end

    // registered copy of comparator flag, no latching
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            threshold_low_n <= 1'b0;
        end else begin
            threshold_low_n <= ~thr_low_s;
        end
    end

endmodule

/* File: bench/ssw_supervisor_assertions.sv */
`timescale 1ns/1ps
module ssw_checker #(
    parameter RST_CYC = 50,
    parameter WD_CYC  = 200
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire supply_low_i,
    input wire threshold_sense_low_i,
    input wire manual_reset_n,
    input wire kick_in,
    input wire kick_float_i,
    input wire sys_reset_n_o,
    input wire watchdog_alarm_n,
    input wire threshold_low_n
);
    reg [15:0] quiet_q;
    reg [15:0] idle_q;
    reg        kick_prev_q;
    always @(posedge clk_i) kick_prev_q <= kick_in;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i || supply_low_i || !manual_reset_n) quiet_q <= 16'h0;
        else quiet_q <= quiet_q + 16'h1;
    end
    // idle counts from raw kick edges, so it restarts before the filtered timer and runs ahead of it
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i || !sys_reset_n_o || kick_float_i || kick_in != kick_prev_q) idle_q <= 16'h0;
        else idle_q <= idle_q + 16'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    thr_low_a: assert property (
        $rose(threshold_sense_low_i) |-> ##[2:4] !threshold_low_n) else $error("thr stuck high");
    thr_high_a: assert property (
        $fell(threshold_sense_low_i) |-> ##[2:4] threshold_low_n) else $error("thr stuck low");
    sup_reset_a: assert property (
        supply_low_i |-> ##[1:4] !sys_reset_n_o) else $error("no reset on supply low");
    sup_alarm_a: assert property (
        supply_low_i |-> ##[1:4] !watchdog_alarm_n) else $error("no alarm on supply low");
    man_reset_a: assert property (
        !manual_reset_n |-> ##[1:4] !sys_reset_n_o) else $error("no manual reset");
    rel_early_a: assert property (
        $rose(sys_reset_n_o) |-> quiet_q >= RST_CYC && quiet_q <= RST_CYC + 6)
        else $error("release off count");
    rel_late_a: assert property (
        quiet_q == RST_CYC + 8 |-> sys_reset_n_o) else $error("release late");
    wd_early_a: assert property (
        $fell(watchdog_alarm_n) |-> !sys_reset_n_o || idle_q >= WD_CYC)
        else $error("alarm early");
    cover property ($rose(sys_reset_n_o));
    cover property ($fell(watchdog_alarm_n) && sys_reset_n_o);
    cover property ($fell(threshold_low_n));
endmodule
bind ssw_supervisor ssw_checker #(.RST_CYC(RST_CYC), .WD_CYC(WD_CYC)) chk_i (.*);

/* File: bench/ssw_host_model.sv */
`timescale 1ns/1ps
module ssw_host_model (
    input  wire clk_i,
    input  wire en_i,
    output reg  kick_o
);
    reg [6:0] cnt_q = 7'h0;
    initial kick_o = 1'b0;
    always @(posedge clk_i) begin
        cnt_q <= en_i ? cnt_q + 7'h1 : 7'h0;
        if (cnt_q == 7'h7F) kick_o <= ~kick_o;
    end
endmodule

/* File: bench/supply_supervisor_watchdog_test.sv */
`timescale 1ns/1ps
module supply_supervisor_watchdog_test;
    reg clk_i, arst_n_i, sup, thr, mr_n, flt, en;
    wire kick, rst_n, alm_n, thr_n;
    integer n_fail = 0;
    integer samples_checked = 0;
    ssw_supervisor #(.RST_CYC(50), .WD_CYC(200)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .supply_low_i(sup), .threshold_sense_low_i(thr), .manual_reset_n(mr_n),
        .kick_in(kick), .kick_float_i(flt), .sys_reset_n_o(rst_n),
        .watchdog_alarm_n(alm_n), .threshold_low_n(thr_n));
    ssw_host_model host (.clk_i(clk_i), .en_i(en), .kick_o(kick));
    task w(input integer n); repeat (n) @(posedge clk_i); endtask
    task chk(input [31:0] nm, input e, input g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0s exp %b got %b", nm, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_power;
        w(10);
        chk("rst", 0, rst_n);
        chk("alm", 0, alm_n);
        sup <= 0;
        w(26);
        chk("alm", 1, alm_n);
        sup <= 1;
        w(6);
        chk("alm", 0, alm_n);
        sup <= 0;
        w(40);
        chk("rst", 0, rst_n);
        w(20);
        chk("rst", 1, rst_n);
        $display("power done");
    endtask
    task t_wd;
        en <= 1;
        w(600);
        chk("alm", 1, alm_n);
        en <= 0;
        w(350);
        chk("alm", 0, alm_n);
        en <= 1;
        w(150);
        chk("alm", 1, alm_n);
        $display("watchdog done");
    endtask
    task t_man;
        mr_n <= 0;
        en <= 0;
        w(300);
        chk("rst", 0, rst_n);
        chk("alm", 1, alm_n);
        mr_n <= 1;
        w(45);
        chk("rst", 0, rst_n);
        w(15);
        chk("rst", 1, rst_n);
        w(150);
        chk("alm", 1, alm_n);
        flt <= 1;
        w(400);
        chk("alm", 1, alm_n);
        flt <= 0;
        thr <= 1;
        w(5);
        chk("thr", 0, thr_n);
        sup <= 1;
        w(5);
        chk("rst", 0, rst_n);
        $display("manual done");
    endtask
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        arst_n_i = 0; sup = 1; thr = 0; mr_n = 1; flt = 0; en = 0;
        w(3);
        arst_n_i <= 1;
        t_power;
        t_wd;
        t_man;
        close_out;
    end
    initial begin
        w(5000);
        n_fail = n_fail + 1;
        close_out;
    end
endmodule
